// [logic/forward_arbiter.v]
// Purpose: Chooses which receive slot is forwarded next
// Assumes: Slots hold one packet each, controls are stable register outputs
// Notes: Pure combinational, the caller registers every result
`include "video_forwarding_control_regs.vh"
module forward_arbiter
(
	input wire [1:0] slotFull, // Slot holds a packet
	input wire [1:0] slotLong, // Held packet is a video line
	input wire [1:0] portOn, // Forwarding enabled per port
	input wire rotating, // Rotating grant mode
	input wire [1:0] syncMode, // Synchronized mode code
	input wire sendWhenReady, // Send lines as available, except in concatenation mode
	input wire [1:0] batchQ, // Ports still owed from current batch
	input wire lastPort, // Port granted last
	output reg grantValid, // A port is granted
	output reg grantPort, // Granted port
	output reg [1:0] candSet, // Set the grant was chosen from
	output reg fromBatch, // Grant belongs to a synchronized batch
	output reg mismatch // Enabled ports hold different packet kinds and alignment is dropped
);
	reg [1:0] avail;
	reg allIn;
	reg kindsDiffer;
	// Grant selection
	always @*
	begin
		avail = slotFull & portOn;
		allIn = (avail == portOn) && (portOn != 2'h0);
		kindsDiffer = (avail == 2'h3) && (slotLong[0] != slotLong[1]);
		candSet = 2'h0;
		fromBatch = 1'b0;
		mismatch = 1'b0;
		if (rotating || syncMode == `SYNC_OFF)
			candSet = avail;
		else if (batchQ != 2'h0)
		begin
			candSet = batchQ & avail;
			fromBatch = 1'b1;
		end
		else if (allIn && !kindsDiffer)
		begin
			candSet = avail;
			fromBatch = 1'b1;
		end
		else if (sendWhenReady && syncMode != `SYNC_CONCAT && (avail & slotLong) != 2'h0)
			candSet = avail & slotLong;
		else if (allIn && kindsDiffer)
		begin
			candSet = avail & slotLong; // Unstick by dropping alignment
			mismatch = 1'b1;
		end
		grantValid = candSet != 2'h0;
		if (candSet == 2'h3)
		begin
			if (rotating || syncMode == `SYNC_INTERLEAVE)
				grantPort = ~lastPort;
			else
				grantPort = 1'b0;
		end
		else
			grantPort = candSet[1];
	end
endmodule // forward_arbiter

// [logic/video_forwarding_control.v]
// Purpose: Forwarding control of a two-input camera hub onto a CSI-2 output with replication
// Assumes: Receive streams and CSI sink run on clk_sys; one packet per handshake
// Notes: Registers over AXI4-Lite; clkEn low freezes all state
//
// The implementer's own choice: register access over AXI4-Lite.
`include "video_forwarding_control_regs.vh"
module video_forwarding_control #(
	parameter DW = 32 // Packet payload width
)
(
	input wire clk_sys, // System clock
	input wire rst, // Synchronous reset, active high
	input wire clkEn, // Clock enable, freezes state when low
	input wire [1:0] rxValid, // Packet offered per receive port
	input wire [2*DW-1:0] rxData, // Packet payload per port
	input wire [1:0] rxLong, // Packet is a video line
	output reg [1:0] rxReady_q, // Slot can take a packet
	output reg out0Valid_q, // CSI output 0 packet valid
	output reg [DW-1:0] out0Data_q, // CSI output 0 payload
	output reg out0Port_q, // Source port of the packet
	output reg out0Long_q, // Packet is a video line
	output reg out0Concat_q, // Packet continues the previous line
	input wire outReady, // CSI outputs accept a packet
	output reg out1Valid_q, // CSI output 1 packet valid
	output reg [DW-1:0] out1Data_q, // CSI output 1 payload
	output reg irq_q, // Level interrupt
	input wire [31:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	output reg s_axi_awready_q, // Write address ready
	input wire [31:0] s_axi_wdata, // Write data
	input wire [3:0] s_axi_wstrb, // Write strobes
	input wire s_axi_wvalid, // Write data valid
	output reg s_axi_wready_q, // Write data ready
	output reg [1:0] s_axi_bresp_q, // Write response
	output reg s_axi_bvalid_q, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire [31:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	output reg s_axi_arready_q, // Read address ready
	output reg [31:0] s_axi_rdata_q, // Read data
	output reg [1:0] s_axi_rresp_q, // Read response
	output reg s_axi_rvalid_q, // Read data valid
	input wire s_axi_rready // Read data ready
);
	reg [7:0] portEnableCtrl_q; // Port enable register
	reg [7:0] modeCtrl_q; // Mode register
	reg [`IRQ_W-1:0] irqStatus_q; // Sticky events
	reg [`IRQ_W-1:0] irqMask_q; // Interrupt mask
	reg syncOk_q; // Synchronized status
	reg syncFail_q; // Sticky failure flag
	reg frameSent_q; // A synchronized frame was completed
	reg [1:0] batch_q; // Ports still owed in batch
	reg lastPort_q; // Last granted port
	reg [DW-1:0] slotData_q [0:1]; // Receive slots
	reg [1:0] slotFull_q; // Slot occupancy
	reg [1:0] slotLong_q; // Slot packet kind
	reg [`REG_ADDR_W-1:0] awAddr_q; // Captured write address
	reg [7:0] wByte_q; // Captured write byte
	reg wLane_q; // Byte lane 0 strobed
	reg awHave_q; // Write address held
	reg wHave_q; // Write data held
	wire [1:0] portOn; // Enabled ports
	wire rotating; // Rotating grant mode
	wire [1:0] syncMode; // Synchronized mode code
	wire grantValid; // Arbiter grant
	wire grantPort; // Granted port
	wire [1:0] candSet; // Candidate set
	wire fromBatch; // Grant from batch
	wire mismatch; // Kind mismatch
	wire outLoad; // Output stage takes a packet
	wire [1:0] batchLeft; // Batch after this grant
	wire batchDone; // Batch finished on this grant
	wire failEvent; // Synchronization lost
	wire okRise; // Sync status rises
	wire wrFire; // Register write happens
	wire rdFire; // Register read happens
	wire [`REG_ADDR_W-1:0] rdAddr; // Read byte address
	wire [1:0] slotTake; // Slot handshake per port
	wire [1:0] slotDrain; // Slot emptied per port
	reg [31:0] rdValue; // Read mux result
	reg rdHit; // Read address mapped
	assign portOn = {~portEnableCtrl_q[`BIT_PORT1_OFF], ~portEnableCtrl_q[`BIT_PORT0_OFF]};
	assign rotating = modeCtrl_q[`BIT_ROTATING];
	assign syncMode = modeCtrl_q[`FLD_SYNC_HI:`FLD_SYNC_LO];
	assign outLoad = grantValid && (!out0Valid_q || outReady);
	assign batchLeft = candSet & ~(grantPort ? 2'h2 : 2'h1);
	assign batchDone = outLoad && fromBatch && (batchLeft == 2'h0);
	assign failEvent = outLoad && mismatch && frameSent_q;
	assign okRise = batchDone && !syncOk_q;
	assign rdAddr = s_axi_araddr[`REG_ADDR_W-1:0];
	assign wrFire = awHave_q && wHave_q && !s_axi_bvalid_q;
	assign rdFire = s_axi_arvalid && s_axi_arready_q;
	// Grant selection for the next forwarded packet
	forward_arbiter u_arbiter (
		.slotFull(slotFull_q),
		.slotLong(slotLong_q),
		.portOn(portOn),
		.rotating(rotating),
		.syncMode(syncMode),
		.sendWhenReady(modeCtrl_q[`BIT_SEND_WHEN_READY]),
		.batchQ(batch_q),
		.lastPort(lastPort_q),
		.grantValid(grantValid),
		.grantPort(grantPort),
		.candSet(candSet),
		.fromBatch(fromBatch),
		.mismatch(mismatch)
	);
	// One holding slot per receive port
	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1)
		begin : gSlot
			assign slotTake[p] = rxValid[p] && rxReady_q[p];
			assign slotDrain[p] = outLoad && (grantPort == p);
			// Slot fill and drain; a disabled port is drained and dropped
			always @(posedge clk_sys)
			begin
				if (rst)
				begin
					slotFull_q[p] <= 1'b0;
					slotLong_q[p] <= 1'b0;
					slotData_q[p] <= {DW{1'b0}};
					rxReady_q[p] <= 1'b0;
				end
				else if (clkEn)
				begin
					if (slotTake[p] && portOn[p])
					begin
						slotFull_q[p] <= 1'b1;
						slotLong_q[p] <= rxLong[p];
						slotData_q[p] <= rxData[p*DW +: DW];
					end
					else if (slotDrain[p] || !portOn[p])
						slotFull_q[p] <= 1'b0;
					// Ready is the registered emptiness of the next cycle
					rxReady_q[p] <= !((slotTake[p] && portOn[p]) || (slotFull_q[p] && !slotDrain[p] && portOn[p]));
				end
			end
		end
	endgenerate
	// Output stage and replicated copy
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			out0Valid_q <= 1'b0;
			out0Data_q <= {DW{1'b0}};
			out0Port_q <= 1'b0;
			out0Long_q <= 1'b0;
			out0Concat_q <= 1'b0;
			out1Valid_q <= 1'b0;
			out1Data_q <= {DW{1'b0}};
			lastPort_q <= 1'b1;
			batch_q <= 2'h0;
		end
		else if (clkEn)
		begin
			if (outLoad)
			begin
				// holds since no grant exists without an enabled full slot
				out0Valid_q <= 1'b1;
				out0Data_q <= slotData_q[grantPort];
				out0Port_q <= grantPort;
				out0Long_q <= slotLong_q[grantPort];
				out0Concat_q <= fromBatch && syncMode == `SYNC_CONCAT && batch_q != 2'h0 &&
					batch_q != portOn && slotLong_q[grantPort];
				out1Valid_q <= modeCtrl_q[`BIT_REPLICATE];
				out1Data_q <= slotData_q[grantPort];
				lastPort_q <= grantPort;
				batch_q <= fromBatch ? batchLeft : batch_q;
			end
			else if (outReady)
			begin
				out0Valid_q <= 1'b0;
				out1Valid_q <= 1'b0;
			end
			if (rotating || syncMode == `SYNC_OFF)
				batch_q <= 2'h0;
		end
	end
	// Synchronization status, failure flag and interrupt
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			syncOk_q <= 1'b0;
			syncFail_q <= 1'b0;
			frameSent_q <= 1'b0;
			irqStatus_q <= {`IRQ_W{1'b0}};
			irq_q <= 1'b0;
		end
		else if (clkEn)
		begin
			if (syncMode == `SYNC_OFF || rotating || failEvent)
				syncOk_q <= 1'b0;
			else if (batchDone)
				syncOk_q <= 1'b1;
			if (syncMode == `SYNC_OFF || rotating)
				frameSent_q <= 1'b0;
			else if (batchDone && !slotLong_q[grantPort] &&
				slotData_q[grantPort][`FLD_DT_HI:`FLD_DT_LO] == `DT_FRAME_END)
				frameSent_q <= 1'b1;
			// Event wins over clear-on-read in the same cycle
			if (failEvent)
				syncFail_q <= 1'b1;
			else if (rdFire && rdAddr == {`IDX_FWD_STATUS, 2'h0})
				syncFail_q <= 1'b0;
			irqStatus_q <= (irqStatus_q & ~((wrFire && wLane_q && awAddr_q == {`IDX_IRQ_STATUS, 2'h0}) ?
				wByte_q[`IRQ_W-1:0] : {`IRQ_W{1'b0}})) | {okRise, failEvent};
			irq_q <= |(irqStatus_q & irqMask_q);
		end
	end
	// Write channel: address and data taken in either order
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			s_axi_awready_q <= 1'b0;
			s_axi_wready_q <= 1'b0;
			s_axi_bvalid_q <= 1'b0;
			s_axi_bresp_q <= `RESP_OKAY;
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			awAddr_q <= {`REG_ADDR_W{1'b0}};
			wByte_q <= 8'h00;
			wLane_q <= 1'b0;
			portEnableCtrl_q <= `RST_PORT_ENABLE;
			modeCtrl_q <= `RST_MODE_CTRL;
			irqMask_q <= {`IRQ_W{1'b0}};
		end
		else if (clkEn)
		begin
			s_axi_awready_q <= !awHave_q && !(s_axi_awvalid && s_axi_awready_q);
			s_axi_wready_q <= !wHave_q && !(s_axi_wvalid && s_axi_wready_q);
			if (s_axi_awvalid && s_axi_awready_q)
			begin
				awHave_q <= 1'b1;
				awAddr_q <= s_axi_awaddr[`REG_ADDR_W-1:0];
			end
			if (s_axi_wvalid && s_axi_wready_q)
			begin
				wHave_q <= 1'b1;
				wByte_q <= s_axi_wdata[7:0];
				wLane_q <= s_axi_wstrb[0];
			end
			if (wrFire)
			begin
				s_axi_bvalid_q <= 1'b1;
				s_axi_bresp_q <= `RESP_OKAY;
				case (awAddr_q)
					{`IDX_PORT_ENABLE, 2'h0}:
						if (wLane_q)
							portEnableCtrl_q <= wByte_q & `PORT_ENABLE_RW_MASK;
					{`IDX_MODE_CTRL, 2'h0}:
						if (wLane_q)
							modeCtrl_q <= wByte_q & `MODE_CTRL_RW_MASK;
					{`IDX_IRQ_MASK, 2'h0}:
						if (wLane_q)
							irqMask_q <= wByte_q[`IRQ_W-1:0];
					{`IDX_IRQ_STATUS, 2'h0}, {`IDX_FWD_STATUS, 2'h0}:
						s_axi_bresp_q <= `RESP_OKAY; // Clearing handled with the flags
					default:
						s_axi_bresp_q <= `RESP_SLVERR;
				endcase
			end
			else if (s_axi_bvalid_q && s_axi_bready)
			begin
				s_axi_bvalid_q <= 1'b0;
				awHave_q <= 1'b0;
				wHave_q <= 1'b0;
				s_axi_awready_q <= 1'b1;
				s_axi_wready_q <= 1'b1;
			end
		end
	end
	// Read mux
	always @*
	begin
		rdValue = 32'h00000000;
		rdHit = 1'b1;
		case (rdAddr)
			{`IDX_PORT_ENABLE, 2'h0}:
				rdValue[7:0] = portEnableCtrl_q;
			{`IDX_MODE_CTRL, 2'h0}:
				rdValue[7:0] = modeCtrl_q;
			{`IDX_FWD_STATUS, 2'h0}:
			begin
				rdValue[`BIT_SYNC_OK] = syncOk_q;
				rdValue[`BIT_SYNC_FAIL] = syncFail_q;
			end
			{`IDX_IRQ_STATUS, 2'h0}:
				rdValue[`IRQ_W-1:0] = irqStatus_q;
			{`IDX_IRQ_MASK, 2'h0}:
				rdValue[`IRQ_W-1:0] = irqMask_q;
			default:
				rdHit = 1'b0;
		endcase
	end
	// Read channel: one read at a time
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			s_axi_arready_q <= 1'b0;
			s_axi_rvalid_q <= 1'b0;
			s_axi_rdata_q <= 32'h00000000;
			s_axi_rresp_q <= `RESP_OKAY;
		end
		else if (clkEn)
		begin
			if (rdFire)
			begin
				s_axi_arready_q <= 1'b0;
				s_axi_rvalid_q <= 1'b1;
				s_axi_rdata_q <= rdValue;
				s_axi_rresp_q <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_rvalid_q && s_axi_rready)
			begin
				s_axi_rvalid_q <= 1'b0;
				s_axi_arready_q <= 1'b1;
			end
			else if (!s_axi_rvalid_q)
				s_axi_arready_q <= 1'b1;
		end
	end
endmodule // video_forwarding_control

// [logic/video_forwarding_control_regs.vh]
// Purpose: Register map, field positions and codes of the video forwarding control block
// Assumes: 32-bit AXI4-Lite word per register, byte address is four times the index
// Notes: Definitions only
`ifndef VIDEO_FORWARDING_CONTROL_REGS_VH
`define VIDEO_FORWARDING_CONTROL_REGS_VH
// Register indices and word addresses
`define IDX_PORT_ENABLE 8'h20
`define IDX_MODE_CTRL 8'h21
`define IDX_FWD_STATUS 8'h22
`define IDX_IRQ_STATUS 8'h23
`define IDX_IRQ_MASK 8'h24
`define REG_ADDR_W 10
// Reset values
`define RST_PORT_ENABLE 8'h30
`define RST_MODE_CTRL 8'h01
// Port enable register fields
`define BIT_PORT1_OFF 5
`define BIT_PORT0_OFF 4
`define PORT_ENABLE_RW_MASK 8'hf0
// Mode register fields
`define BIT_REPLICATE 7
`define BIT_SEND_WHEN_READY 6
`define FLD_SYNC_HI 3
`define FLD_SYNC_LO 2
`define BIT_ROTATING 0
`define MODE_CTRL_RW_MASK 8'hcf
// Synchronized mode codes
`define SYNC_OFF 2'h0
`define SYNC_BASIC 2'h1
`define SYNC_INTERLEAVE 2'h2
`define SYNC_CONCAT 2'h3
// Status bits (forwarding status and interrupt status)
`define BIT_SYNC_OK 0
`define BIT_SYNC_FAIL 2
`define IRQ_BIT_FAIL 0
`define IRQ_BIT_SYNC_RISE 1
`define IRQ_W 2
// Short packet data type marking frame end
`define DT_FRAME_END 6'h01
`define FLD_DT_HI 5
`define FLD_DT_LO 0
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [verification/csi_sink_model.sv]
// Purpose: Stand-in for the CSI-2 receiver that takes output packets
// Assumes: One shared ready for both outputs, single clock
// Notes: Prompt mode always ready, slow mode ready one cycle in four
module csi_sink_model
(
	input wire clk_sys, // System clock
	input wire rst, // Synchronous reset
	input wire slow, // Stall most cycles
	input wire out0Valid_q, // Packet offered
	output reg outReady // Packet accepted
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [1:0] pace_q; // Stall pacing counter
	// Paces the ready line; low in reset
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			pace_q <= 2'h0;
			outReady <= 1'b0;
		end
		else
		begin
			pace_q <= pace_q + 2'h1;
			outReady <= !slow || (pace_q == 2'h3);
		end
	end
endmodule // csi_sink_model

// [verification/video_forwarding_control_asserts.sv]
// Purpose: Port-level checks of the forwarding control block
// Assumes: One clock domain, synchronous active-high reset
// Notes: Attached by bind, watches design outputs
module video_forwarding_control_asserts #(
	parameter DW = 32 // Payload width
)
(
	input wire clk_sys, // System clock
	input wire rst, // Reset
	input wire clkEn, // Clock enable
	input wire out0Valid_q, // Output 0 valid
	input wire [DW-1:0] out0Data_q, // Output 0 payload
	input wire out0Port_q, // Source port
	input wire out0Long_q, // Video line
	input wire out0Concat_q, // Continuation
	input wire outReady, // Sink ready
	input wire out1Valid_q, // Output 1 valid
	input wire [DW-1:0] out1Data_q, // Output 1 payload
	input wire irq_q, // Interrupt
	input wire s_axi_awvalid, // Write address valid
	input wire s_axi_awready_q, // Write address ready
	input wire s_axi_wvalid, // Write data valid
	input wire s_axi_wready_q, // Write data ready
	input wire [1:0] s_axi_bresp_q, // Write response
	input wire s_axi_bvalid_q, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire s_axi_arvalid, // Read address valid
	input wire s_axi_arready_q, // Read address ready
	input wire [31:0] s_axi_rdata_q, // Read data
	input wire s_axi_rvalid_q, // Read valid
	input wire s_axi_rready // Read ready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst || !clkEn);
	// Address and data of a write taken together
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready_q && s_axi_wvalid && s_axi_wready_q;
	endsequence
	// Read address taken
	sequence rdTaken;
		s_axi_arvalid && s_axi_arready_q;
	endsequence
	a_write_answer: assert property (wrTaken |-> ##2 s_axi_bvalid_q) else $error("write not answered");
	a_read_answer: assert property (rdTaken |=> s_axi_rvalid_q && !s_axi_arready_q) else $error("read not answered");
	a_bresp_stands: assert property (s_axi_bvalid_q && !s_axi_bready |=> s_axi_bvalid_q && $stable(s_axi_bresp_q))
		else $error("write response dropped");
	a_rdata_stands: assert property (s_axi_rvalid_q && !s_axi_rready |=> s_axi_rvalid_q && $stable(s_axi_rdata_q))
		else $error("read data dropped");
	a_upper_zero: assert property (s_axi_rvalid_q |-> s_axi_rdata_q[31:8] == 24'h0) else $error("upper bits set");
	a_write_refused: assert property (s_axi_bvalid_q |-> !s_axi_awready_q && !s_axi_wready_q)
		else $error("write taken while pending");
	a_out_stands: assert property (
		out0Valid_q && !outReady |=> out0Valid_q && $stable(out0Data_q) && $stable(out0Port_q))
		else $error("output packet changed while stalled");
	a_replica_same: assert property (
		out1Valid_q |-> out0Valid_q && out1Data_q == out0Data_q) else $error("replica differs");
	a_concat_line: assert property (
		out0Valid_q && out0Concat_q |-> out0Long_q && out0Port_q) else $error("bad continuation");
	a_reset_quiet: assert property (
		$fell(rst) |-> !out0Valid_q && !irq_q ##1 !out0Valid_q) else $error("output after reset");
endmodule // video_forwarding_control_asserts
bind video_forwarding_control video_forwarding_control_asserts #(.DW(DW)) chk (.clk_sys, .rst, .clkEn,
	.out0Valid_q, .out0Data_q, .out0Port_q, .out0Long_q, .out0Concat_q, .outReady, .out1Valid_q, .out1Data_q,
	.irq_q, .s_axi_awvalid, .s_axi_awready_q, .s_axi_wvalid, .s_axi_wready_q, .s_axi_bresp_q, .s_axi_bvalid_q,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready_q, .s_axi_rdata_q, .s_axi_rvalid_q, .s_axi_rready);

// [verification/video_forwarding_control_tb.sv]
// Purpose: Self-checking bench of the forwarding control block
// Assumes: Packets checked per source port against bench queues
// Notes: Register traffic over AXI4-Lite, sink model paces output
`include "video_forwarding_control_regs.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module video_forwarding_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	reg clk_sys = 1'b0, rst = 1'b1, clkEn = 1'b1, slow = 1'b0; // Clock, reset, sink pacing
	reg [1:0] rxValid = 2'h0, rxLong = 2'h0; // Receive handshake
	reg [63:0] rxData = 64'h0; // Receive payloads
	reg [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	reg [3:0] s_axi_wstrb = 4'hf;
	reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire [1:0] rxReady_q, s_axi_bresp_q, s_axi_rresp_q;
	wire [31:0] out0Data_q, out1Data_q, s_axi_rdata_q;
	wire out0Valid_q, out0Port_q, out0Long_q, out0Concat_q, outReady, out1Valid_q, irq_q;
	wire s_axi_awready_q, s_axi_wready_q, s_axi_bvalid_q, s_axi_arready_q, s_axi_rvalid_q;
	int error_cnt = 0, checks_done = 0, k; // Counters
	reg [32:0] q0[$], q1[$], expD; // Expected kind and payload per port
	reg [5:0] dtShort = 6'h02; // Data type of short packets sent
	reg expCat = 1'b0; // Port 1 lines continue the batch line
	int ord[$]; // Order of delivered ports
	reg [1:0] en = 2'h0; // Ports enabled in the model
	reg repl = 1'b0; // Replication in the model
	reg [15:0] lfsr_q = 16'h2312; // Random state
	reg [7:0] mt [4] = '{8'h04, 8'h48, 8'h48, 8'h4c}; // Sync mode rows
	video_forwarding_control #(.DW(32)) dut (.clk_sys, .rst, .clkEn, .rxValid, .rxData, .rxLong, .rxReady_q,
		.out0Valid_q, .out0Data_q, .out0Port_q, .out0Long_q, .out0Concat_q, .outReady, .out1Valid_q, .out1Data_q,
		.irq_q, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready_q, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready_q, .s_axi_bresp_q, .s_axi_bvalid_q, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready_q, .s_axi_rdata_q, .s_axi_rresp_q, .s_axi_rvalid_q, .s_axi_rready);
	csi_sink_model sink (.clk_sys, .rst, .slow, .out0Valid_q, .outReady);
	always #4 clk_sys = ~clk_sys;
	function [15:0] lfsr(input [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task summarize;
		begin
			$display("checks=%0d errors=%0d", checks_done, error_cnt);
			if (error_cnt == 0 && checks_done > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// A wait ran out
	task tmo;
		begin
			error_cnt++;
			$display("[ERR] t=%0t wait limit got=%h exp=%h", $time, 1'b0, 1'b1);
			summarize;
		end
	endtask
	// Every packet taken by the sink is matched to its port queue
	always @(negedge clk_sys)
		if (out0Valid_q === 1'b1 && outReady === 1'b1)
		begin
			ord.push_back(out0Port_q);
			`CHK((out0Port_q ? q1.size() : q0.size()) > 0, 1'b1)
			expD = out0Port_q ? q1.pop_front() : q0.pop_front();
			`CHK({out0Long_q, out0Data_q}, expD)
			`CHK(out0Concat_q, expCat && out0Port_q)
			if (repl)
				`CHK({out1Valid_q, out1Data_q}, {1'b1, out0Data_q})
		end
	// One register access, write or read, held until answered
	task axi(input reg isWr, input [31:0] a, input [7:0] d, output [31:0] r, output [1:0] rsp);
		int n;
		reg aw, w, ar, dn;
		begin
			dn = 1'b0;
			if (isWr)
			begin
				s_axi_awaddr <= a;
				s_axi_wdata <= {24'h0, d};
				s_axi_awvalid <= 1'b1;
				s_axi_wvalid <= 1'b1;
				s_axi_bready <= 1'b1;
			end
			else
			begin
				s_axi_araddr <= a;
				s_axi_arvalid <= 1'b1;
				s_axi_rready <= 1'b1;
			end
			for (n = 0; n < 40 && !dn; n++)
			begin
				@(negedge clk_sys);
				aw = s_axi_awvalid && s_axi_awready_q;
				w = s_axi_wvalid && s_axi_wready_q;
				ar = s_axi_arvalid && s_axi_arready_q;
				dn = (isWr ? s_axi_bvalid_q && s_axi_bready : s_axi_rvalid_q && s_axi_rready) === 1'b1;
				r = s_axi_rdata_q;
				rsp = isWr ? s_axi_bresp_q : s_axi_rresp_q;
				@(posedge clk_sys);
				if (aw)
					s_axi_awvalid <= 1'b0;
				if (w)
					s_axi_wvalid <= 1'b0;
				if (ar)
					s_axi_arvalid <= 1'b0;
				if (dn)
				begin
					s_axi_bready <= 1'b0;
					s_axi_rready <= 1'b0;
				end
			end
			if (!dn)
				tmo;
			@(posedge clk_sys);
		end
	endtask
	task wr(input [31:0] a, input [7:0] d);
		reg [31:0] r;
		reg [1:0] s;
		begin
			if (a == 32'h80)
				en = ~d[5:4];
			if (a == 32'h84)
				repl = d[7];
			axi(1'b1, a, d, r, s);
			`CHK(s, `RESP_OKAY)
		end
	endtask
	task rdChk(input [31:0] a, input [31:0] m, input [31:0] e, input [1:0] es);
		reg [31:0] r;
		reg [1:0] s;
		begin
			axi(1'b0, a, 8'h0, r, s);
			`CHK({s, r & m}, {es, e})
		end
	endtask
	// Offers a random packet on each port in the mask
	task send(input [1:0] m, input [1:0] lg);
		int n, p;
		reg [1:0] tk, left;
		reg [31:0] d;
		begin
			left = m;
			for (p = 0; p < 2; p++)
				if (m[p])
				begin
					lfsr_q = lfsr(lfsr_q);
					d = {lfsr_q, ~lfsr_q};
					if (!lg[p])
						d[5:0] = dtShort;
					rxData[p*32 +: 32] <= d;
					rxLong[p] <= lg[p];
					rxValid[p] <= 1'b1;
					if (en[p] && p == 1)
						q1.push_back({lg[p], d});
					else if (en[p])
						q0.push_back({lg[p], d});
				end
			for (n = 0; n < 60 && left !== 2'h0; n++)
			begin
				@(negedge clk_sys);
				tk = left & rxValid & rxReady_q;
				@(posedge clk_sys);
				left = left & ~tk;
				rxValid <= rxValid & ~tk;
			end
			if (left !== 2'h0)
				tmo;
			@(posedge clk_sys);
		end
	endtask
	task drain;
		int n;
		begin
			for (n = 0; n < 200 && q0.size() + q1.size() != 0; n++)
				@(posedge clk_sys);
			if (q0.size() + q1.size() != 0)
				tmo;
		end
	endtask
	// Main sequence
	initial
	begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rdChk(32'h80, 32'hffffffff, {24'h0, `RST_PORT_ENABLE}, `RESP_OKAY);
		rdChk(32'h84, 32'hffffffff, {24'h0, `RST_MODE_CTRL}, `RESP_OKAY);
		rdChk(32'hfc, 32'hffffffff, 32'h0, `RESP_SLVERR);
		send(2'h3, 2'h3);
		repeat (10) @(posedge clk_sys);
		wr(32'h80, 8'hff);
		rdChk(32'h80, 32'hffffffff, 32'hf0, `RESP_OKAY);
		wr(32'h84, 8'hfe);
		rdChk(32'h84, 32'hffffffff, 32'hce, `RESP_OKAY);
		wr(32'h84, 8'h01);
		wr(32'h80, 8'h20);
		send(2'h3, 2'h3);
		drain;
		wr(32'h80, 8'h00);
		wr(32'h84, 8'h81);
		slow <= 1'b1;
		ord.delete();
		send(2'h3, 2'h3);
		send(2'h3, 2'h3);
		drain;
		`CHK({ord[0] != ord[1], ord[2] != ord[3]}, 2'h3)
		slow <= 1'b0;
		for (k = 0; k < 4; k++)
		begin
			wr(32'h84, mt[k]);
			expCat = k == 3;
			send(2'h2, {2{k != 2}});
			repeat (12) @(posedge clk_sys);
			`CHK(q1.size(), int'(k != 1))
			send(2'h1, {2{k != 2}});
			drain;
		end
		// Frame end batch, then a line meets a short packet and alignment is lost
		expCat = 1'b0;
		dtShort = `DT_FRAME_END;
		send(2'h3, 2'h0);
		drain;
		dtShort = 6'h02;
		send(2'h2, 2'h2);
		send(2'h1, 2'h0);
		repeat (12) @(posedge clk_sys);
		`CHK(q0.size() * 2 + q1.size(), 2)
		send(2'h2, 2'h0);
		drain;
		rdChk(32'h88, 32'h5, 32'h5, `RESP_OKAY);
		rdChk(32'h88, 32'h4, 32'h0, `RESP_OKAY);
		rdChk(32'h8c, 32'h3, 32'h3, `RESP_OKAY);
		@(negedge clk_sys);
		`CHK(irq_q, 1'b0)
		@(posedge clk_sys);
		wr(32'h90, 8'h02);
		repeat (2) @(negedge clk_sys);
		`CHK(irq_q, 1'b1)
		@(posedge clk_sys);
		wr(32'h8c, 8'h02);
		repeat (2) @(negedge clk_sys);
		`CHK(irq_q, 1'b0)
		@(posedge clk_sys);
		wr(32'h84, 8'h01);
		rdChk(32'h88, 32'h1, 32'h0, `RESP_OKAY);
		summarize;
	end
endmodule // video_forwarding_control_tb
